// file: src/can_bit_timing_consts.svh
// Constants of the CAN bit timing block: offsets, fields, resets, counts.
// Assumes inclusion by the package and the design modules of this block.
//
// Contract
// R1: One quantum lasts two times (prescale value plus one) clock periods.
// R2: Bit time is quantum times total quanta per bit; rate is reciprocal.
// R3: Software programs at least eight quanta per bit for correct operation.
// R4: Every bit opens with a one quantum synchronization segment.
// R5: Three-bit field sets the propagation segment from one to eight quanta.
// R6: Phase one is one to eight quanta; the bit is sampled at its end.
// R7: Phase two is one to eight quanta but never shorter than two.
// R8: Two quanta of processing time start at the sample point.
// R9: Triple sample select takes a majority of three half-quantum samples.
// R10: Source select picks phase two from its field or max(phase one, 2).
// R11: Hard synchronization only on a falling edge while the bus is idle.
// R12: At most one synchronization per bit time.
// R13: Two-bit jump width of one to four quanta bounds every adjustment.
// R14: Only recessive-to-dominant edges carry timing information.
// R15: Phase error in quanta: zero in sync, positive early, negative late.
// R16: Error within the jump width resynchronizes like a hard sync.
// R17: Larger positive error lengthens phase one by exactly the jump width.
// R18: Larger negative error shortens phase two by exactly the jump width.
// R19: Edge used only if the previous sample differs from the level after.
// R20: While sending dominant, no resync on a positive phase error edge.
// R21: Software keeps prop plus phase one >= phase two >= jump width.
// R22: Timing registers accept writes only in configuration mode.
`ifndef CAN_BIT_TIMING_CONSTS_SVH
`define CAN_BIT_TIMING_CONSTS_SVH

// Register byte offsets
`define OFS_PRESCALE_JUMP 8'h00
`define OFS_SEGMENTS 8'h04
`define OFS_PHASE_TWO 8'h08
`define OFS_CONTROL 8'h0c
`define OFS_STATUS 8'h10

// Field positions
`define POS_JUMP_MSB 7
`define POS_JUMP_LSB 6
`define POS_PRESCALE_MSB 5
`define POS_SOURCE_SEL 7
`define POS_TRIPLE_SEL 6
`define POS_PHASE_ONE_MSB 5
`define POS_PHASE_ONE_LSB 3
`define POS_PROP_MSB 2
`define POS_PHASE_TWO_MSB 2
`define POS_CONFIG_MODE 0

// Reset values
`define RST_TIMING_REG 8'h00
`define RST_CONFIG_MODE 1'b1

// Timing counts in quanta, and clocks per prescale step
`define SYNC_SEG_TQ 5'h01
`define IPT_TQ 5'h02
`define CLOCKS_PER_PRESCALE_STEP 2

`endif

// file: src/can_bit_timing_pkg.sv
// Types shared by the CAN bit timing block.
// Assumes the constants header is on the include path.
package can_bit_timing_pkg;
  `include "can_bit_timing_consts.svh"

  typedef struct packed {
    logic [1:0] jumpField;
    logic [5:0] quantumPrescaleValue;
    logic phaseTwoSourceSelect;
    logic tripleSampleSelect;
    logic [2:0] phaseOneLengthField;
    logic [2:0] propagationLengthField;
    logic [2:0] phaseTwoLengthField;
  } timing_cfg_type;

  typedef enum logic [2:0] {
    ST_SYNC = 3'b001,
    ST_SEG1 = 3'b010,
    ST_SEG2 = 3'b100
  } bit_state_type;
endpackage : can_bit_timing_pkg

// file: src/quantum_prescaler.sv
// Time quantum divider with a half-quantum enable.
// Assumes one system clock; restart realigns the quantum to an edge.
`timescale 1ns/1ps
`default_nettype none
module quantum_prescaler
  import can_bit_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic [5:0] prescale,
  input wire logic restart,
  // Enables
  output logic tqTick,
  output logic halfTick
);
  logic [6:0] clkCount;
  logic [6:0] halfLast;
  logic [6:0] fullLast;

  assign halfLast = {1'b0, prescale};
  assign fullLast = 7'({prescale, 1'b1}); // [R1]
  assign tqTick = (clkCount == fullLast);
  assign halfTick = (clkCount == halfLast) || tqTick;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clkCount <= 7'h00;
    end else if (restart || tqTick) begin
      clkCount <= 7'h00;
    end else begin
      clkCount <= clkCount + 7'h01;
    end
  end
endmodule : quantum_prescaler
`default_nettype wire

// file: src/sample_voter.sv
// Majority vote over the receive pin at half-quantum spacing.
// Assumes the pin is synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module sample_voter
  import can_bit_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Sampling
  input wire logic halfTick,
  input wire logic tripleSel,
  input wire logic pinLevel,
  // Result
  output logic busLevel
);
  logic [1:0] earlySamples;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      earlySamples <= 2'b11;
    end else if (halfTick) begin
      earlySamples <= {earlySamples[0], pinLevel};
    end
  end

  // Samples at the point and one and two half quanta earlier
  always_comb begin
    if (tripleSel) begin // [R9]
      busLevel = (earlySamples[0] & earlySamples[1]) |
                 (earlySamples[0] & pinLevel) |
                 (earlySamples[1] & pinLevel);
    end else begin
      busLevel = pinLevel;
    end
  end
endmodule : sample_voter
`default_nettype wire

// file: src/can_bit_timing_logic.sv
// CAN bit timing: quanta, segments, sample point and synchronization.
// Assumes an APB master and a receive pin synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
// Offsets, fields and counts
`include "can_bit_timing_consts.svh"
module can_bit_timing_logic
  import can_bit_timing_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bus pins and protocol side
  input wire logic busReceivePin,
  input wire logic busIdle,
  input wire logic txDominant,
  // Timing outputs
  output logic samplePoint,
  output logic bitStart,
  output logic rxBit
);
  timing_cfg_type cfg;
  bit_state_type state;
  logic configMode;
  logic [4:0] tqCount;
  logic [4:0] seg1Extra;
  logic [4:0] seg2Cut;
  logic syncDone;
  logic pinPrev;
  logic tqTick;
  logic halfTick;
  logic votedLevel;
  logic [4:0] seg1Len;
  logic [4:0] seg1Target;
  logic [4:0] seg2Len;
  logic [4:0] seg2Target;
  logic [4:0] jumpLen;
  logic [4:0] posError;
  logic [4:0] negError;
  logic fallEdge;
  logic edgeUsable;
  logic hardSync;
  logic resyncRestart;
  logic lengthenNow;
  logic shortenNow;
  logic syncNow;
  logic seg1Ends;
  logic seg2Ends;
  logic setupPhase;
  logic accessWrite;
  logic next_pslverr;
  logic [31:0] next_prdata;

  // Segment length from a zero-based field
  function automatic logic [4:0] fieldLen(input logic [2:0] field);
    fieldLen = {2'b00, field} + 5'h01;
  endfunction : fieldLen

  function automatic logic [4:0] maxLen(input logic [4:0] a,
                                        input logic [4:0] b);
    maxLen = (a > b) ? a : b;
  endfunction : maxLen

  // Derived segment lengths
  assign jumpLen = {3'b000, cfg.jumpField} + 5'h01; // [R13]
  assign seg1Len = fieldLen(cfg.propagationLengthField) +
                   fieldLen(cfg.phaseOneLengthField); // [R5] [R6]
  assign seg1Target = seg1Len + seg1Extra; // [R17]

  always_comb begin
    if (cfg.phaseTwoSourceSelect) begin // [R10]
      seg2Len = maxLen(fieldLen(cfg.phaseTwoLengthField), `IPT_TQ); // [R7]
    end else begin
      seg2Len = maxLen(fieldLen(cfg.phaseOneLengthField), `IPT_TQ); // [R8]
    end
  end

  assign seg2Target = seg2Len - seg2Cut; // [R18]

  // Quantum divider restarted on hard syncs and on resyncs within the jump width
  quantum_prescaler quantumDivider (
    .clk_sys(clk_sys),
    .rst(rst),
    .prescale(cfg.quantumPrescaleValue),
    .restart(syncNow || configMode),
    .tqTick(tqTick),
    .halfTick(halfTick)
  );

  sample_voter pinVoter (
    .clk_sys(clk_sys),
    .rst(rst),
    .halfTick(halfTick),
    .tripleSel(cfg.tripleSampleSelect),
    .pinLevel(busReceivePin),
    .busLevel(votedLevel)
  );

  // Edge qualification
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinPrev <= 1'b1;
    end else begin
      pinPrev <= busReceivePin;
    end
  end

  assign fallEdge = pinPrev && !busReceivePin; // [R14]
  assign edgeUsable = fallEdge && rxBit && !syncDone &&
                      !configMode; // [R19] [R12]

  // Phase error in quanta relative to the sync segment
  assign posError = (state == ST_SEG1) ? tqCount + 5'h01 : 5'h00; // [R15]
  assign negError = (state == ST_SEG2) ? seg2Target - tqCount : 5'h00;

  // Synchronization decisions
  assign hardSync = edgeUsable && busIdle; // [R11]
  always_comb begin
    resyncRestart = 1'b0;
    lengthenNow = 1'b0;
    shortenNow = 1'b0;
    if (edgeUsable && !busIdle) begin
      case (state)
        ST_SYNC: begin
          resyncRestart = 1'b1;
        end
        ST_SEG1: begin
          if (!txDominant) begin // [R20]
            if (posError <= jumpLen) begin
              resyncRestart = 1'b1; // [R16]
            end else begin
              lengthenNow = 1'b1; // [R17]
            end
          end
        end
        ST_SEG2: begin
          if (negError <= jumpLen) begin
            resyncRestart = 1'b1; // [R16]
          end else begin
            shortenNow = 1'b1; // [R18]
          end
        end
        default: begin
          resyncRestart = 1'b0;
        end
      endcase
    end
  end

  assign syncNow = hardSync || resyncRestart;
  assign seg1Ends = tqTick && (state == ST_SEG1) &&
                    (tqCount + 5'h01 >= seg1Target);
  assign seg2Ends = tqTick && (state == ST_SEG2) &&
                    (tqCount + 5'h01 >= seg2Target);

  // Segment sequencing
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_SYNC;
      tqCount <= 5'h00;
    end else if (configMode || syncNow) begin
      state <= ST_SYNC; // [R11] [R16]
      tqCount <= 5'h00;
    end else if (tqTick) begin
      case (state)
        ST_SYNC: begin
          if (tqCount + 5'h01 >= `SYNC_SEG_TQ) begin // [R4]
            state <= ST_SEG1;
            tqCount <= 5'h00;
          end else begin
            tqCount <= tqCount + 5'h01;
          end
        end
        ST_SEG1: begin
          if (seg1Ends) begin // [R6]
            state <= ST_SEG2;
            tqCount <= 5'h00;
          end else begin
            tqCount <= tqCount + 5'h01;
          end
        end
        ST_SEG2: begin
          if (seg2Ends) begin // [R2]
            state <= ST_SYNC;
            tqCount <= 5'h00;
          end else begin
            tqCount <= tqCount + 5'h01;
          end
        end
        default: begin
          state <= ST_SYNC;
          tqCount <= 5'h00;
        end
      endcase
    end
  end

  // Per-bit adjustments and the one-sync guard
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seg1Extra <= 5'h00;
      seg2Cut <= 5'h00;
      syncDone <= 1'b0;
    end else if (configMode) begin
      seg1Extra <= 5'h00;
      seg2Cut <= 5'h00;
      syncDone <= 1'b0;
    end else if (syncNow) begin
      // A sync in the last quantum opens the next bit already synced
      seg1Extra <= 5'h00;
      seg2Cut <= 5'h00;
      syncDone <= 1'b1; // [R12]
    end else if (seg2Ends) begin
      seg1Extra <= 5'h00;
      seg2Cut <= 5'h00;
      syncDone <= 1'b0;
    end else if (lengthenNow) begin
      seg1Extra <= jumpLen; // [R17]
      syncDone <= 1'b1;
    end else if (shortenNow) begin
      seg2Cut <= jumpLen; // [R18]
      syncDone <= 1'b1;
    end
  end

  // Sample point and received bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      samplePoint <= 1'b0;
      rxBit <= 1'b1;
    end else begin
      samplePoint <= seg1Ends && !configMode;
      if (seg1Ends && !configMode) begin
        rxBit <= votedLevel; // [R6] [R9]
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bitStart <= 1'b0;
    end else begin
      bitStart <= !configMode && (syncNow || seg2Ends); // [R4]
    end
  end

  // APB register access
  assign setupPhase = psel && !penable;
  assign accessWrite = psel && penable && pwrite;
  assign pready = 1'b1;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg <= '0;
    end else if (accessWrite && configMode) begin // [R22]
      case (paddr)
        `OFS_PRESCALE_JUMP: begin
          cfg.jumpField <= pwdata[`POS_JUMP_MSB:`POS_JUMP_LSB];
          cfg.quantumPrescaleValue <= pwdata[`POS_PRESCALE_MSB:0];
        end
        `OFS_SEGMENTS: begin
          cfg.phaseTwoSourceSelect <= pwdata[`POS_SOURCE_SEL];
          cfg.tripleSampleSelect <= pwdata[`POS_TRIPLE_SEL];
          cfg.phaseOneLengthField <=
            pwdata[`POS_PHASE_ONE_MSB:`POS_PHASE_ONE_LSB];
          cfg.propagationLengthField <= pwdata[`POS_PROP_MSB:0];
        end
        `OFS_PHASE_TWO: begin
          cfg.phaseTwoLengthField <= pwdata[`POS_PHASE_TWO_MSB:0];
        end
        default: begin
          cfg <= cfg;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      configMode <= `RST_CONFIG_MODE;
    end else if (accessWrite && paddr == `OFS_CONTROL) begin
      configMode <= pwdata[`POS_CONFIG_MODE];
    end
  end

  // Read data and error prepared in the setup cycle
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      `OFS_PRESCALE_JUMP: begin
        next_prdata[7:0] = {cfg.jumpField, cfg.quantumPrescaleValue};
      end
      `OFS_SEGMENTS: begin
        next_prdata[7:0] = {cfg.phaseTwoSourceSelect,
                            cfg.tripleSampleSelect,
                            cfg.phaseOneLengthField,
                            cfg.propagationLengthField};
      end
      `OFS_PHASE_TWO: begin
        next_prdata[7:0] = {5'h00, cfg.phaseTwoLengthField};
      end
      `OFS_CONTROL: begin
        next_prdata[0] = configMode;
      end
      `OFS_STATUS: begin
        next_prdata[7:0] = {1'b0, configMode, syncDone, state,
                            busReceivePin, rxBit};
      end
      default: begin
        next_pslverr = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end
endmodule : can_bit_timing_logic
`default_nettype wire

// file: verification/can_bit_timing_checker.sv
// Port checker of the CAN bit timing block.
// Assumes it is bound to can_bit_timing_logic on one clock.
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Timing outputs
  input wire logic samplePoint,
  input wire logic bitStart,
  input wire logic rxBit
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic acc = psel && penable;
  sequence quietSample;
    !samplePoint [*5];
  endsequence
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_sample_pulse: assert property (samplePoint |=> !samplePoint)
    else $error("sample pulse too long");
  chk_start_pulse: assert property (bitStart |=> !bitStart)
    else $error("bit start pulse too long");
  chk_rx_at_sample: assert property ($changed(rxBit) |->
    samplePoint || $past(samplePoint)) else $error("rx bit off sample");
  chk_start_then_sample: assert property (bitStart |=> quietSample)
    else $error("sample too soon after bit start");
  chk_sample_spacing: assert property (samplePoint |=> quietSample)
    else $error("samples too close");
  chk_err_unmapped: assert property (acc && paddr > 8'h10 |-> pslverr)
    else $error("no error on unmapped address");
  chk_err_mapped: assert property (acc && paddr inside {8'h00, 8'h04,
    8'h08, 8'h0c} |-> !pslverr) else $error("error on mapped address");
  chk_read_upper: assert property (acc && !pwrite |->
    prdata[31:8] == 24'h0) else $error("upper read bits set");
endmodule : can_bit_timing_checker
bind can_bit_timing_logic can_bit_timing_checker u_chk (.clk_sys, .rst,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .samplePoint, .bitStart, .rxBit);
`default_nettype wire

// file: verification/can_node_model.sv
// Other nodes on the shared line, as seen at the receive pin.
// Assumes the bench commands the wired level after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
  // Clock
  input wire logic clk_sys,
  // Command
  input wire logic level,
  // Line
  output logic busReceivePin
);
  // Line idles recessive; level changes only just after an edge
  initial busReceivePin = 1'b1;
  always @(posedge clk_sys) begin
    busReceivePin <= level;
  end
endmodule : can_node_model
`default_nettype wire

// file: verification/tb.sv
// Bench of the CAN bit timing block: registers, bit time, sync.
// Assumes the node model drives the receive pin.
`timescale 1ns/1ps
`default_nettype none
`include "can_bit_timing_consts.svh"
module tb;
  import can_bit_timing_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, busIdle, txDominant, level;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, busReceivePin, samplePoint, bitStart, rxBit;
  int miscompares, checksDone;
  // Prescale/jump, segments, phase two, clocks to sample, clocks per bit
  localparam logic [55:0] ROWS [8] = '{56'h00_0a_00_000c_0010,
    56'h01_0a_00_0018_0020, 56'h3f_0a_00_0300_0400,
    56'h00_89_03_000a_0012, 56'h00_8a_00_000c_0010,
    56'h00_1b_00_0012_001a, 56'h00_0a_07_000c_0010,
    56'h00_4a_00_000c_0010};
  can_node_model u_node (.clk_sys, .level, .busReceivePin);
  can_bit_timing_logic dut (.clk_sys, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .busReceivePin, .busIdle,
    .txDominant, .samplePoint, .bitStart, .rxBit);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [7:0] d, output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      check(0, 1);
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic setup(input logic [7:0] pj, sg, p2);
    wr(`OFS_CONTROL, 8'h01);
    wr(`OFS_PRESCALE_JUMP, pj);
    wr(`OFS_SEGMENTS, sg);
    wr(`OFS_PHASE_TWO, p2);
    wr(`OFS_CONTROL, 8'h00);
  endtask : setup
  task automatic wait_on(input bit start, output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while ((start ? bitStart : samplePoint) !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      check(0, 1);
      tally_and_finish();
    end
  endtask : wait_on
  task automatic edge_bit(input int k, input logic lv, output int len);
    int n;
    wait_on(1'b1, n);
    repeat (k) @(posedge clk_sys);
    level <= lv;
    wait_on(1'b1, n);
    len = k + n;
  endtask : edge_bit
  task automatic test_regs;
    logic [31:0] r;
    logic e;
    for (int a = 0; a < 12; a += 4) begin
      apb(1'b0, a[7:0], 8'h00, r, e);
      check(r, 32'h0);
    end
    apb(1'b0, `OFS_CONTROL, 8'h00, r, e);
    check(r, 32'h1);
    apb(1'b0, `OFS_STATUS, 8'h00, r, e);
    check(r, 32'h47);
    wr(`OFS_SEGMENTS, 8'ha5);
    wr(`OFS_CONTROL, 8'h00);
    wr(`OFS_SEGMENTS, 8'h5a);
    apb(1'b0, `OFS_SEGMENTS, 8'h00, r, e);
    check(r, 32'ha5);
    apb(1'b0, 8'h14, 8'h00, r, e);
    check({r[30:0], e}, 32'h1);
    $display("test regs done");
  endtask : test_regs
  task automatic test_bit_time;
    int n, m;
    foreach (ROWS[i]) begin
      setup(ROWS[i][55:48], ROWS[i][47:40], ROWS[i][39:32]);
      wait_on(1'b1, n);
      wait_on(1'b0, n);
      check(n, ROWS[i][31:16]);
      wait_on(1'b1, m);
      check(n + m, ROWS[i][15:0]);
      check(rxBit, 1'b1);
    end
    @(posedge clk_sys);
    level <= 1'b0;
    wait_on(1'b0, n);
    wait_on(1'b0, n);
    check(rxBit, 1'b0);
    @(posedge clk_sys);
    level <= 1'b1;
    wait_on(1'b0, n);
    wait_on(1'b0, n);
    $display("test bit time done");
  endtask : test_bit_time
  task automatic test_sync;
    int len;
    setup(8'h00, 8'h1b, 8'h00);
    @(posedge clk_sys);
    busIdle <= 1'b1;
    edge_bit(8, 1'b0, len);
    check(len > 8 && len <= 12, 1'b1);
    @(posedge clk_sys);
    busIdle <= 1'b0;
    edge_bit(8, 1'b1, len);
    check(len, 26);
    edge_bit(8, 1'b0, len);
    check(len, 28);
    edge_bit(8, 1'b1, len);
    check(len, 26);
    @(posedge clk_sys);
    txDominant <= 1'b1;
    edge_bit(8, 1'b0, len);
    check(len, 26);
    @(posedge clk_sys);
    txDominant <= 1'b0;
    edge_bit(8, 1'b1, len);
    edge_bit(20, 1'b0, len);
    check(len, 24);
    edge_bit(8, 1'b1, len);
    setup(8'hc0, 8'h1b, 8'h00);
    edge_bit(4, 1'b0, len);
    check(len <= 8, 1'b1);
    $display("test sync done");
  endtask : test_sync
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, busIdle, txDominant} = 5'h00;
    level = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    test_regs();
    test_bit_time();
    test_sync();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
